/* regbuf_defines.vh */
/*
 Constants for the 28-bit 1:2 registered command buffer (register-B pin map).
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef REGBUF_DEFINES_VH
`define REGBUF_DEFINES_VH

// ==================================================
// Widths
`define RB_WORD_W 28
`define RB_DATA_W 22
`define RB_HOLD_W 2

// ==================================================
// Positions of the module-dependent bits in the 28-bit word (bit n-1 is pin n)
`define RB_POS_ODT1 12
`define RB_POS_ODT0 13
`define RB_POS_CS0 14
`define RB_POS_CS1 15
`define RB_POS_CKE0 20
`define RB_POS_CKE1 22

// ==================================================
// Fields of the 22-bit data port as they sit in the word
`define RB_FLD_TOP_HI 21
`define RB_FLD_TOP_LO 17
`define RB_FLD_MID_POS 16
`define RB_FLD_LOW_HI 15
`define RB_FLD_LOW_LO 12
`define RB_FLD_BASE_HI 11

// ==================================================
// Reset values and timing
`define RB_WORD_RST 28'h0000000
`define RB_ERR_IDLE 1'b1
`define RB_ERR_HOLD_CYCLES 2'h2
`define RB_HOLD_ZERO 2'h0
`define RB_HOLD_ONE 2'h1

`endif

/* parity_check.v */
/*
 Even-parity checker: registers the parity of a data word, combines it with the
 parity bit that arrives one clock later, and reports the result on the next edge.
 Assumes same-clock inputs and the asynchronous active-low reset of its parent.
*/
`timescale 1ns/100ps
`include "regbuf_defines.vh"

module parity_check (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Word under check
	input wire [`RB_DATA_W-1:0] data_word,
	input wire word_valid,
	input wire parity_bit,
	// Result, one edge after the parity bit
	output reg check_valid_reg,
	output reg check_error_reg
);

	// ==================================================
	// Stage 1: parity of the data word and its validity
	reg data_parity_reg;
	reg data_valid_reg;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_parity_reg <= 1'b0;
			data_valid_reg <= 1'b0;
		end else begin
			data_parity_reg <= ^data_word;
			data_valid_reg <= word_valid;
		end
	end

	// ==================================================
	// Stage 2: late parity bit joins the word's parity
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			check_valid_reg <= 1'b0;
			check_error_reg <= 1'b0;
		end else begin
			check_valid_reg <= data_valid_reg;
			check_error_reg <= data_parity_reg ^ parity_bit;
		end
	end

endmodule // parity_check

/* regbuf_b.v */
/*
 28-bit 1:2 registered address/command buffer, register-B pin map, with even
 parity checking, latched active-low error output and chip-select gated low power.
 Assumes the controller runs on clk, holds reset_n low through power-up until clk
 is stable, and presents each parity bit one clock after its data word.
*/
// Operation
// - All inputs except reset_n are captured on the rising clock edge.
// - Each registered bit drives an A copy and a B copy.
// - Reset clears registers, outputs low, error output held high.
// - During reset inputs are ignored; undriven inputs do not affect outputs.
// - Reset acts asynchronously, independent of clock edges.
// - Entering reset clears registers and drives outputs low at once.
// - After reset release outputs stay low until receivers are enabled.
// - Odd count of ones over data plus parity bit flags an error.
// - Both chip selects and gate enable high enter low-power state.
// - Error output, once low, stays low at least two clocks.
// - Error before low power stays low through it plus two clocks.
// - Error output updates two clocks after its data is registered.
// - Both chip selects high freezes the error output.
// - Gate enable and both chip selects high hold data outputs.
// - Chip selects, clock enables and terminations are excluded from parity.
`timescale 1ns/100ps
`include "regbuf_defines.vh"

module regbuf_b (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Gate configuration
	input wire select_gate_enable,
	// DIMM-independent inputs: D1-D12, D17-D20, D22, D24-D28, low bit first
	input wire [`RB_DATA_W-1:0] data_in,
	input wire parity_bit_in,
	// DIMM-dependent inputs
	input wire termination_ctrl_in_0,
	input wire termination_ctrl_in_1,
	input wire chip_select_in_0_n,
	input wire chip_select_in_1_n,
	input wire dram_clk_en_in_0,
	input wire dram_clk_en_in_1,
	// Registered outputs, bit n-1 is output n
	output wire [`RB_WORD_W-1:0] q_a,
	output wire [`RB_WORD_W-1:0] q_b,
	// Named views of the control outputs
	output wire termination_ctrl_out_0a,
	output wire termination_ctrl_out_0b,
	output wire termination_ctrl_out_1a,
	output wire termination_ctrl_out_1b,
	output wire chip_select_out_0a_n,
	output wire chip_select_out_0b_n,
	output wire chip_select_out_1a_n,
	output wire chip_select_out_1b_n,
	output wire dram_clk_en_out_0a,
	output wire dram_clk_en_out_0b,
	output wire dram_clk_en_out_1a,
	output wire dram_clk_en_out_1b,
	// Status
	output wire parity_error_out_n,
	output wire low_power_state
);

	// ==================================================
	// Receiver enable after reset release
	// Inputs other than select_gate_enable read as inactive (chip selects high, the rest low) for the first edge after release, so undriven pins
	// seen while the receivers settle cannot glitch the outputs.
	reg rx_ready_reg;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rx_ready_reg <= 1'b0;
		else
			rx_ready_reg <= 1'b1;
	end

	// ==================================================
	// Input qualification and word assembly
	wire [`RB_DATA_W-1:0] data_q;
	wire cs0_q_n;
	wire cs1_q_n;
	wire both_cs_high;
	wire gate_active;
	wire [`RB_WORD_W-1:0] word_in;

	assign data_q = rx_ready_reg ? data_in : {`RB_DATA_W{1'b0}};
	// Chip selects read inactive until the receivers are up
	assign cs0_q_n = rx_ready_reg ? chip_select_in_0_n : 1'b1;
	assign cs1_q_n = rx_ready_reg ? chip_select_in_1_n : 1'b1;
	assign both_cs_high = cs0_q_n & cs1_q_n;
	assign gate_active = select_gate_enable & both_cs_high;

	// Register-B map: controls at pins 13-16, 21 and 23
	assign word_in = {
		data_q[`RB_FLD_TOP_HI:`RB_FLD_TOP_LO],
		rx_ready_reg & dram_clk_en_in_1,
		data_q[`RB_FLD_MID_POS],
		rx_ready_reg & dram_clk_en_in_0,
		data_q[`RB_FLD_LOW_HI:`RB_FLD_LOW_LO],
		cs1_q_n & rx_ready_reg,
		cs0_q_n & rx_ready_reg,
		rx_ready_reg & termination_ctrl_in_0,
		rx_ready_reg & termination_ctrl_in_1,
		data_q[`RB_FLD_BASE_HI:0]
	};

	// Bits that always update, even in low power
	function is_control_bit;
		input integer pos;
		begin
			is_control_bit = (pos == `RB_POS_ODT1) || (pos == `RB_POS_ODT0) ||
				(pos == `RB_POS_CS0) || (pos == `RB_POS_CS1) ||
				(pos == `RB_POS_CKE0) || (pos == `RB_POS_CKE1);
		end
	endfunction

	// ==================================================
	// Output registers, two copies per bit
	// Separate flops per copy keep each output's fan-out on its own driver.
	reg [`RB_WORD_W-1:0] q_a_reg;
	reg [`RB_WORD_W-1:0] q_b_reg;
	reg lpm_reg;

	genvar i;
	generate
		for (i = 0; i < `RB_WORD_W; i = i + 1) begin : g_bit
			wire hold_bit;
			assign hold_bit = gate_active && !is_control_bit(i);
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					q_a_reg[i] <= 1'b0;
					q_b_reg[i] <= 1'b0;
				end else if (!hold_bit) begin
					q_a_reg[i] <= word_in[i];
					q_b_reg[i] <= word_in[i];
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lpm_reg <= 1'b0;
		else
			lpm_reg <= gate_active;
	end

	assign q_a = q_a_reg;
	assign q_b = q_b_reg;
	assign low_power_state = lpm_reg;

	assign termination_ctrl_out_0a = q_a_reg[`RB_POS_ODT0];
	assign termination_ctrl_out_0b = q_b_reg[`RB_POS_ODT0];
	assign termination_ctrl_out_1a = q_a_reg[`RB_POS_ODT1];
	assign termination_ctrl_out_1b = q_b_reg[`RB_POS_ODT1];
	assign chip_select_out_0a_n = q_a_reg[`RB_POS_CS0];
	assign chip_select_out_0b_n = q_b_reg[`RB_POS_CS0];
	assign chip_select_out_1a_n = q_a_reg[`RB_POS_CS1];
	assign chip_select_out_1b_n = q_b_reg[`RB_POS_CS1];
	assign dram_clk_en_out_0a = q_a_reg[`RB_POS_CKE0];
	assign dram_clk_en_out_0b = q_b_reg[`RB_POS_CKE0];
	assign dram_clk_en_out_1a = q_a_reg[`RB_POS_CKE1];
	assign dram_clk_en_out_1b = q_b_reg[`RB_POS_CKE1];

	// ==================================================
	// Parity pipeline
	// Only DIMM-independent inputs feed the checker; a word counts only when a
	// chip select was low with it.
	wire check_valid;
	wire check_error;
	wire parity_q;

	assign parity_q = rx_ready_reg & parity_bit_in;

	parity_check u_parity (
		.clk(clk),
		.reset_n(reset_n),
		.data_word(data_q),
		.word_valid(~both_cs_high),
		.parity_bit(parity_q),
		.check_valid_reg(check_valid),
		.check_error_reg(check_error)
	);

	// ==================================================
	// Error latch
	// The hold counter freezes with the output while both chip selects are
	// high, which stretches an error taken before low power by its length.
	reg err_n_reg;
	reg err_n_next;
	reg [`RB_HOLD_W-1:0] hold_reg;
	reg [`RB_HOLD_W-1:0] hold_next;

	always @* begin
		err_n_next = err_n_reg;
		hold_next = hold_reg;
		if (both_cs_high) begin
			err_n_next = err_n_reg;
			hold_next = hold_reg;
		end else if (check_valid && check_error) begin
			err_n_next = 1'b0;
			hold_next = `RB_ERR_HOLD_CYCLES - `RB_HOLD_ONE;
		end else if (!err_n_reg) begin
			if (hold_reg != `RB_HOLD_ZERO)
				hold_next = hold_reg - `RB_HOLD_ONE;
			else
				err_n_next = `RB_ERR_IDLE;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			err_n_reg <= `RB_ERR_IDLE;
			hold_reg <= `RB_HOLD_ZERO;
		end else begin
			err_n_reg <= err_n_next;
			hold_reg <= hold_next;
		end
	end

	assign parity_error_out_n = err_n_reg;

endmodule // regbuf_b

/* regbuf_checker.sv */
/* Port checker for regbuf_b, bound to it at the foot.
   Assumes one clock, clk, and the active-low reset_n. */
`timescale 1ns/100ps
module regbuf_checker (
	// Inputs
	input wire logic clk,
	input wire logic reset_n,
	input wire logic select_gate_enable,
	input wire logic [21:0] data_in,
	input wire logic parity_bit_in,
	input wire logic chip_select_in_0_n,
	input wire logic chip_select_in_1_n,
	// Outputs
	input wire logic [27:0] q_a,
	input wire logic [27:0] q_b,
	input wire logic chip_select_out_0b_n,
	input wire logic parity_error_out_n,
	input wire logic low_power_state
);
	wire logic hi = chip_select_in_0_n & chip_select_in_1_n;
	wire logic gate = select_gate_enable & hi;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ====
	// Assertions; data, select and low-power checks take two edges of margin after reset for the receiver model
	chk_copy_pair: assert property (q_a == q_b) else $error("copies differ");
	chk_data_take: assert property ($past(reset_n, 2) && !$past(gate) |-> q_a[11:0] == $past(data_in[11:0]))
		else $error("data not taken");
	chk_gate_hold: assert property ($past(reset_n, 2) && $past(gate) |-> $stable(q_a[27:23]))
		else $error("gated data moved");
	chk_ctrl_copy: assert property ($past(reset_n, 2) |-> chip_select_out_0b_n == $past(chip_select_in_0_n))
		else $error("select not copied");
	chk_low_power: assert property ($past(reset_n, 2) |-> low_power_state == $past(gate))
		else $error("low power wrong");
	chk_err_freeze: assert property ($past(reset_n) && $past(hi) |-> $stable(parity_error_out_n))
		else $error("error moved while frozen");
	chk_err_hold: assert property ($fell(parity_error_out_n) |=> !parity_error_out_n)
		else $error("error too short");
	chk_err_cause: assert property ($fell(parity_error_out_n) |-> !$past(hi, 3) && ^{$past(data_in, 3), $past(parity_bit_in, 2)})
		else $error("error without cause");
	cov_err: cover property ($fell(parity_error_out_n));
	cov_lpm: cover property ($rose(low_power_state));
	cov_frz: cover property (!parity_error_out_n && low_power_state);
endmodule // regbuf_checker
bind regbuf_b regbuf_checker chk_u (.clk, .reset_n, .select_gate_enable, .data_in, .parity_bit_in,
	.chip_select_in_0_n, .chip_select_in_1_n, .q_a, .q_b, .chip_select_out_0b_n, .parity_error_out_n, .low_power_state);

/* ctrl_parity_model.sv */
/* Controller-side parity source for the buffer bench.
   Assumes data_in changes just after rising clk edges. */
`timescale 1ns/100ps
module ctrl_parity_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Word and deliberate fault
	input wire logic [21:0] data_in,
	input wire logic flip,
	// Parity out
	output logic parity_bit_in
);
	// Even parity one cycle behind its word; flip only when the bench asks
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			parity_bit_in <= 1'b0;
		else
			parity_bit_in <= ^data_in ^ flip;
	end
endmodule // ctrl_parity_model

/* tb.sv */
/* Bench for regbuf_b: random words, parity faults, low power, resets.
   Assumes the design, the parity model and the bound checker. */
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b1;
	logic select_gate_enable = 1'b0;
	logic [21:0] data_in = 22'h0;
	logic termination_ctrl_in_0 = 1'b0;
	logic termination_ctrl_in_1 = 1'b0;
	logic dram_clk_en_in_0 = 1'b0;
	logic dram_clk_en_in_1 = 1'b0;
	logic chip_select_in_0_n = 1'b1;
	logic chip_select_in_1_n = 1'b1;
	logic flip = 1'b0;
	wire logic parity_bit_in, parity_error_out_n, low_power_state;
	wire logic [27:0] q_a, q_b;
	wire logic [11:0] ctl_o;
	logic [11:0] ectl;
	logic [29:0] exp_q[$];
	logic [29:0] e;
	logic [27:0] mq;
	logic merr, pn, h1, h2;
	logic [3:0] r;
	integer seed = 70;
	integer miscompares = 0;
	integer n_compared = 0;
	// ====
	// Design and controller model
	regbuf_b dut_u (.clk, .reset_n, .select_gate_enable, .data_in, .parity_bit_in, .termination_ctrl_in_0,
		.termination_ctrl_in_1, .chip_select_in_0_n, .chip_select_in_1_n, .dram_clk_en_in_0, .dram_clk_en_in_1,
		.q_a, .q_b, .termination_ctrl_out_0a(ctl_o[0]), .termination_ctrl_out_0b(ctl_o[1]),
		.termination_ctrl_out_1a(ctl_o[2]), .termination_ctrl_out_1b(ctl_o[3]),
		.chip_select_out_0a_n(ctl_o[4]), .chip_select_out_0b_n(ctl_o[5]),
		.chip_select_out_1a_n(ctl_o[6]), .chip_select_out_1b_n(ctl_o[7]),
		.dram_clk_en_out_0a(ctl_o[8]), .dram_clk_en_out_0b(ctl_o[9]),
		.dram_clk_en_out_1a(ctl_o[10]), .dram_clk_en_out_1b(ctl_o[11]),
		.parity_error_out_n, .low_power_state);
	ctrl_parity_model partner_u (.clk, .reset_n, .data_in, .flip, .parity_bit_in);
	always #10 clk = ~clk;
	// ====
	// Tasks
	task automatic check(input logic [29:0] seen, input logic [29:0] want);
		n_compared++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d miscompared %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic step(input logic g, input logic c0, input logic c1, input logic f);
		logic [21:0] d;
		logic [3:0] k;
		d = 22'($random(seed));
		k = 4'($random(seed));
		@(posedge clk);
		data_in <= d;
		{termination_ctrl_in_0, termination_ctrl_in_1, dram_clk_en_in_0, dram_clk_en_in_1} <= k;
		select_gate_enable <= g;
		chip_select_in_0_n <= c0;
		chip_select_in_1_n <= c1;
		flip <= f;
		// Control bits are taken even while data is gated
		mq = ((g & c0 & c1) ? mq : {d[21:17], 1'b0, d[16], 1'b0, d[15:12], 4'h0, d[11:0]}) & ~28'h050f000
			| {5'h0, k[0], 1'b0, k[1], 4'h0, c1, c0, k[3], k[2], 12'h0};
		if (!(c0 & c1)) begin
			merr = !(h2 | pn);
			pn = h2;
		end
		h2 = h1;
		h1 = f & !(c0 & c1);
		exp_q.push_back({merr, g & c0 & c1, mq});
	endtask
	task automatic do_reset;
		reset_n <= 1'b0;
		data_in <= 'z;
		select_gate_enable <= 1'b0;
		chip_select_in_0_n <= 1'b1;
		chip_select_in_1_n <= 1'b1;
		exp_q.delete();
		{mq, merr, pn, h1, h2} = {28'h0, 4'h8};
		#1 check({parity_error_out_n, low_power_state, q_a}, {2'b10, 28'h0});
		repeat (5) @(posedge clk);
		check({parity_error_out_n, low_power_state, q_a}, {2'b10, 28'h0});
		reset_n <= 1'b1;
		data_in <= 22'h0;
		@(posedge clk);
		#1 check({parity_error_out_n, low_power_state, q_a & ~28'h050f000}, {2'b10, 28'h0});
	endtask
	// ====
	// Result watcher, settled at the falling edge
	always @(negedge clk) begin
		if (exp_q.size() > 1) begin
			e = exp_q.pop_front();
			check({2'b0, q_a}, {2'b0, e[27:0]});
			check({29'h0, low_power_state}, {29'h0, e[28]});
			check({29'h0, parity_error_out_n}, {29'h0, e[29]});
			check({28'h0, parity_error_out_n, low_power_state}, {28'h0, e[29:28]});
			check({2'b0, q_b}, {2'b0, e[27:0]});
			// Named views: cke1, cke0, cs1, cs0, odt1, odt0, each as b then a copy
			ectl = {{2{e[22]}}, {2{e[20]}}, {2{e[15]}}, {2{e[14]}}, {2{e[12]}}, {2{e[13]}}};
			check({18'h0, ctl_o}, {18'h0, ectl});
		end
	end
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		complete_run();
	end
	initial begin
		do_reset();
		repeat (40) begin
			r = 4'($random(seed));
			step(r[0], 1'b0, r[1], 1'b0);
		end
		step(1'b0, 1'b1, 1'b0, 1'b1);
		repeat (3) step(1'b0, 1'b1, 1'b0, 1'b0);
		repeat (3) step(1'b1, 1'b0, 1'b0, 1'b1);
		repeat (3) step(1'b1, 1'b0, 1'b1, 1'b0);
		// Error shows, then low power holds it
		step(1'b1, 1'b0, 1'b1, 1'b1);
		repeat (2) step(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (5) step(1'b1, 1'b1, 1'b1, 1'b1);
		repeat (4) step(1'b0, 1'b1, 1'b1, 1'b0);
		repeat (4) step(1'b0, 1'b0, 1'b1, 1'b0);
		repeat (200) begin
			r = 4'($random(seed));
			step(r[0], r[1], r[2], r[3]);
		end
		do_reset();
		repeat (10) step(1'b0, 1'b0, 1'b0, 1'b1);
		complete_run();
	end
endmodule // tb
